// file: src/bls_pkg.sv
package bls_pkg;
    localparam logic [7:0] OPC_READ_LOCK     = 8'h3d;
    localparam logic [7:0] OPC_GLOBAL_LOCK   = 8'h7e;
    localparam logic [7:0] OPC_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OPC_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OPC_RESET         = 8'h99;

    localparam int         INDEX_W      = 10;
    localparam int         LOCK_ENTRIES = 1024;
    localparam int         INDEX_LSB    = 16;
    localparam logic [5:0] ADDR_BITS_3B = 6'h18;
    localparam logic [5:0] ADDR_BITS_4B = 6'h20;
    localparam logic [5:0] OPC_BITS     = 6'h08;
    localparam logic       LOCK_RESET   = 1'b1;

    localparam int         CLK_PERIOD_NS = 100;
    localparam int         RST_TIME_NS   = 30000;
    localparam logic [8:0] RST_CYCLES    = 9'(RST_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        ST_OPCODE  = 4'b0001,
        ST_ADDRESS = 4'b0010,
        ST_READOUT = 4'b0100,
        ST_IGNORE  = 4'b1000
    } bls_state_type;
endpackage : bls_pkg

// file: src/bls_lock_if.sv
`timescale 1ns/1ps
interface bls_lock_if;
    logic [9:0] query_index;
    logic       query_locked;
    logic [9:0] prot_index;
    logic       prot_locked;
    logic       set_all;
    logic       clear_all;

    modport ctrl (
        output query_index,
        output prot_index,
        output set_all,
        output clear_all,
        input  query_locked,
        input  prot_locked
    );
    modport store (
        input  query_index,
        input  prot_index,
        input  set_all,
        input  clear_all,
        output query_locked,
        output prot_locked
    );
endinterface : bls_lock_if

// file: src/bls_lock_store.sv
`timescale 1ns/1ps
module bls_lock_store (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control side.
    bls_lock_if.store lk
);
    logic [bls_pkg::LOCK_ENTRIES-1:0] lock_bits;
    logic [bls_pkg::LOCK_ENTRIES-1:0] next_lock_bits;

    genvar i;
    generate
        for (i = 0; i < bls_pkg::LOCK_ENTRIES; i = i + 1) begin : g_entry
            always_comb begin
                next_lock_bits[i] = lock_bits[i];
                if (lk.set_all) begin
                    next_lock_bits[i] = 1'b1;
                end else if (lk.clear_all) begin
                    next_lock_bits[i] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_bits <= {bls_pkg::LOCK_ENTRIES{bls_pkg::LOCK_RESET}};
        end else begin
            lock_bits <= next_lock_bits;
        end
    end

    assign lk.query_locked = lock_bits[lk.query_index];
    assign lk.prot_locked  = lock_bits[lk.prot_index];
endmodule : bls_lock_store

// file: src/bls_cmd.sv
`timescale 1ns/1ps
// Functional notes
// - Lock bits guard the array only when write_protect_select is one.
// - With select zero, protection follows complement, top/bottom, range.
// - Lock bits are volatile and come up as one after any reset.
// - Lock value leaves on falling clock edges, high bit first.
// - Returned byte has low bit one when locked, zero when unlocked.
// - Lone 7Eh then chip select high sets every lock bit.
// - Lone 98h then chip select high clears every lock bit.
// - Accepted reset aborts work and drops every volatile setting.
// - Any command other than 66h or 99h after arming disarms the reset.
// - About 30 us of reset follows, all commands rejected meanwhile.
// - Busy is one during internal operations, zero when ready.
module bls_cmd (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial link pins.
    input  wire logic       cs_n_pin,
    input  wire logic       sclk_pin,
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_out_oe,
    // Protection configuration.
    input  wire logic       write_protect_select,
    input  wire logic       protect_complement,
    input  wire logic       top_bottom_select,
    input  wire logic [3:0] protect_range_bits,
    input  wire logic       addr_4byte,
    // Array protection query.
    input  wire logic [9:0] prot_index,
    output logic            prot_locked,
    // Status and reset to the rest of the device.
    input  wire logic       array_op_busy,
    output logic            status_busy,
    output logic            soft_reset_pulse
);
    bls_lock_if lk ();

    bls_lock_store u_store (
        .clk (clk),
        .rst (rst),
        .lk  (lk.store)
    );

    logic cs_s1, cs_s2, cs_s3;
    logic ck_s1, ck_s2, ck_s3;
    logic di_s1, di_s2;

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            di_s1 <= 1'b0;
            di_s2 <= 1'b0;
        end else begin
            cs_s1 <= cs_n_pin;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            ck_s1 <= sclk_pin;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            di_s1 <= serial_in;
            di_s2 <= di_s1;
        end
    end

    logic cs_rise;
    logic ck_rise;
    logic ck_fall;
    assign cs_rise = cs_s2 & ~cs_s3;
    assign ck_rise = ck_s2 & ~ck_s3;
    assign ck_fall = ~ck_s2 & ck_s3;

    bls_pkg::bls_state_type state, next_state;
    logic [7:0]  opcode, next_opcode;
    logic [31:0] addr, next_addr;
    logic [5:0]  bit_cnt, next_bit_cnt;
    logic [2:0]  out_cnt, next_out_cnt;
    logic [7:0]  out_byte, next_out_byte;
    logic [9:0]  q_index, next_q_index;
    logic        armed, next_armed;
    logic [8:0]  rst_cnt, next_rst_cnt;
    logic        set_all, next_set_all;
    logic        clear_all, next_clear_all;
    logic        next_serial_out, next_serial_out_oe;
    logic        next_status_busy, next_soft_reset_pulse;
    logic [7:0]  opc_full;
    logic [31:0] addr_full;
    logic [5:0]  addr_bits;

    always_comb begin
        next_state            = state;
        next_opcode           = opcode;
        next_addr             = addr;
        next_bit_cnt          = bit_cnt;
        next_out_cnt          = out_cnt;
        next_out_byte         = out_byte;
        next_q_index          = q_index;
        next_armed            = armed;
        next_rst_cnt          = rst_cnt;
        next_set_all          = 1'b0;
        next_clear_all        = 1'b0;
        next_serial_out       = serial_out;
        next_serial_out_oe    = serial_out_oe;
        next_soft_reset_pulse = 1'b0;
        opc_full  = {opcode[6:0], di_s2};
        addr_full = {addr[30:0], di_s2};
        addr_bits = addr_4byte ? bls_pkg::ADDR_BITS_4B
                               : bls_pkg::ADDR_BITS_3B;
        if (rst_cnt != 9'h000) begin
            next_rst_cnt = rst_cnt - 9'h001;
        end
        if (cs_s2) begin
            next_state         = bls_pkg::ST_OPCODE;
            next_bit_cnt       = 6'h00;
            next_addr          = 32'h0000_0000;
            next_serial_out_oe = 1'b0;
            next_serial_out    = 1'b0;
            if (cs_rise && state == bls_pkg::ST_OPCODE &&
                bit_cnt == bls_pkg::OPC_BITS && rst_cnt == 9'h000) begin
                unique case (opcode)
                    bls_pkg::OPC_GLOBAL_LOCK: begin
                        next_set_all = 1'b1;
                    end
                    bls_pkg::OPC_GLOBAL_UNLOCK: begin
                        next_clear_all = 1'b1;
                    end
                    bls_pkg::OPC_RESET_ENABLE: begin
                        next_armed = 1'b1;
                    end
                    bls_pkg::OPC_RESET: begin
                        if (armed) begin
                            next_armed            = 1'b0;
                            next_set_all          = 1'b1;
                            next_soft_reset_pulse = 1'b1;
                            next_rst_cnt          = bls_pkg::RST_CYCLES;
                        end
                    end
                    default: begin
                        next_armed = 1'b0;
                    end
                endcase
            end
        end else if (rst_cnt != 9'h000) begin
            next_state = bls_pkg::ST_IGNORE;
        end else begin
            unique case (state)
                bls_pkg::ST_OPCODE: begin
                    if (ck_rise) begin
                        if (bit_cnt == bls_pkg::OPC_BITS) begin
                            next_state = bls_pkg::ST_IGNORE;
                        end else begin
                            next_opcode  = opc_full;
                            next_bit_cnt = bit_cnt + 6'h01;
                        end
                        if (bit_cnt == bls_pkg::OPC_BITS - 6'h01) begin
                            if (opc_full != bls_pkg::OPC_RESET_ENABLE &&
                                opc_full != bls_pkg::OPC_RESET) begin
                                next_armed = 1'b0;
                            end
                            if (opc_full == bls_pkg::OPC_READ_LOCK) begin
                                next_state   = bls_pkg::ST_ADDRESS;
                                next_bit_cnt = 6'h00;
                            end
                        end
                    end
                end
                bls_pkg::ST_ADDRESS: begin
                    if (ck_rise) begin
                        next_addr    = addr_full;
                        next_bit_cnt = bit_cnt + 6'h01;
                        if (bit_cnt == addr_bits - 6'h01) begin
                            next_state   = bls_pkg::ST_READOUT;
                            next_q_index = addr_full[bls_pkg::INDEX_LSB +:
                                                     bls_pkg::INDEX_W];
                            next_out_cnt = 3'h0;
                        end
                    end
                end
                bls_pkg::ST_READOUT: begin
                    next_out_byte = {7'h00, lk.query_locked};
                    if (ck_fall) begin
                        next_serial_out    = next_out_byte[3'h7 - out_cnt];
                        next_serial_out_oe = 1'b1;
                        next_out_cnt       = out_cnt + 3'h1;
                    end
                end
                bls_pkg::ST_IGNORE: begin
                    next_state = bls_pkg::ST_IGNORE;
                end
            endcase
        end
        next_status_busy = array_op_busy | (next_rst_cnt != 9'h000);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state            <= bls_pkg::ST_OPCODE;
            opcode           <= 8'h00;
            addr             <= 32'h0000_0000;
            bit_cnt          <= 6'h00;
            out_cnt          <= 3'h0;
            out_byte         <= 8'h00;
            q_index          <= 10'h000;
            armed            <= 1'b0;
            rst_cnt          <= 9'h000;
            set_all          <= 1'b0;
            clear_all        <= 1'b0;
            serial_out       <= 1'b0;
            serial_out_oe    <= 1'b0;
            status_busy      <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            state            <= next_state;
            opcode           <= next_opcode;
            addr             <= next_addr;
            bit_cnt          <= next_bit_cnt;
            out_cnt          <= next_out_cnt;
            out_byte         <= next_out_byte;
            q_index          <= next_q_index;
            armed            <= next_armed;
            rst_cnt          <= next_rst_cnt;
            set_all          <= next_set_all;
            clear_all        <= next_clear_all;
            serial_out       <= next_serial_out;
            serial_out_oe    <= next_serial_out_oe;
            status_busy      <= next_status_busy;
            soft_reset_pulse <= next_soft_reset_pulse;
        end
    end

    assign lk.query_index = q_index;
    assign lk.prot_index  = prot_index;
    assign lk.set_all     = set_all;
    assign lk.clear_all   = clear_all;

    // Range protection: 2^(n-1) blocks at the top, or bottom when selected.
    logic [14:0] range_size;
    logic [14:0] idx_wide;
    logic        in_range;
    logic        next_prot_locked;

    always_comb begin
        range_size = 15'h0000;
        if (protect_range_bits != 4'h0) begin
            range_size = 15'h0001 << (protect_range_bits - 4'h1);
        end
        idx_wide = {5'h00, prot_index};
        if (top_bottom_select) begin
            in_range = idx_wide < range_size;
        end else begin
            in_range = (idx_wide + range_size) >= 15'h0400;
        end
        if (write_protect_select) begin
            next_prot_locked = lk.prot_locked;
        end else begin
            next_prot_locked = in_range ^ protect_complement;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prot_locked <= 1'b1;
        end else begin
            prot_locked <= next_prot_locked;
        end
    end
endmodule : bls_cmd

// file: tb/bls_cmd_asserts.sv
`timescale 1ns/1ps
module bls_cmd_asserts (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst,
    // Serial link.
    input wire logic       cs_n_pin,
    input wire logic       serial_out_oe,
    // Protection.
    input wire logic       write_protect_select,
    input wire logic       protect_complement,
    input wire logic [3:0] protect_range_bits,
    input wire logic       prot_locked,
    // Status.
    input wire logic       array_op_busy,
    input wire logic       status_busy,
    input wire logic       soft_reset_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    // Counts cycles since the last accepted software reset.
    always_comb begin
        next_cnt = cnt;
        if (soft_reset_pulse)
            next_cnt = 10'h000;
        else if (cnt != 10'h3ff)
            next_cnt = cnt + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (rst)
            cnt <= 10'h3ff;
        else
            cnt <= next_cnt;
    end
    sequence s_no_range;
        !write_protect_select && !protect_complement
            && protect_range_bits == 4'h0;
    endsequence
    sequence s_full_range;
        !write_protect_select && (protect_complement
            ? protect_range_bits == 4'h0 : protect_range_bits == 4'hf);
    endsequence
    property p_rst_vals;
        disable iff (1'b0) rst |=> prot_locked && !status_busy
            && !soft_reset_pulse && !serial_out_oe;
    endproperty
    property p_no_range; s_no_range [*2] |-> !prot_locked; endproperty
    property p_full_range; s_full_range [*2] |-> prot_locked; endproperty
    property p_busy_follow; array_op_busy |=> status_busy; endproperty
    property p_pulse_one; soft_reset_pulse |=> !soft_reset_pulse; endproperty
    property p_pulse_busy; soft_reset_pulse |-> status_busy; endproperty
    property p_busy_hold;
        cnt > 10'h000 && cnt < 10'h122 |-> status_busy;
    endproperty
    property p_busy_end;
        cnt == 10'h136 && !$past(array_op_busy) |-> !status_busy;
    endproperty
    property p_oe_idle; cs_n_pin [*5] |-> !serial_out_oe; endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset values wrong");
    a_no_range: assert property (p_no_range)
        else $error("protected with no range");
    a_full_range: assert property (p_full_range)
        else $error("unprotected with full range");
    a_busy_follow: assert property (p_busy_follow)
        else $error("busy missing during array op");
    a_pulse_one: assert property (p_pulse_one)
        else $error("reset pulse too long");
    a_pulse_busy: assert property (p_pulse_busy)
        else $error("busy low at reset pulse");
    a_busy_hold: assert property (p_busy_hold)
        else $error("reset interval ended early");
    a_busy_end: assert property (p_busy_end)
        else $error("reset interval too long");
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while deselected");
endmodule : bls_cmd_asserts

bind bls_cmd bls_cmd_asserts u_asserts (
    .clk, .rst, .cs_n_pin, .serial_out_oe, .write_protect_select,
    .protect_complement, .protect_range_bits, .prot_locked,
    .array_op_busy, .status_busy, .soft_reset_pulse
);

// file: tb/bls_host.sv
`timescale 1ns/1ps
module bls_host (
    // Clock.
    input  wire logic clk,
    // Serial link.
    output logic      cs_n_pin,
    output logic      sclk_pin,
    output logic      serial_in,
    input  wire logic serial_out
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        serial_in = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask : half
    // Shifts opcode and address bits out, then reads nrd bytes back.
    task automatic frame(input logic [7:0] op, input int nop,
                         input logic [31:0] adr, input int nad,
                         input int nrd, output logic [7:0] rd);
        logic [39:0] sh;
        sh = {op, adr << (32 - nad)};
        rd = 8'h00;
        cs_n_pin <= 1'b0;
        half();
        for (int i = 0; i < nop + nad; i++) begin
            serial_in <= sh[39 - i];
            half();
            sclk_pin <= 1'b1;
            half();
            sclk_pin <= 1'b0;
        end
        for (int i = 0; i < 8 * nrd; i++) begin
            half();
            sclk_pin <= 1'b1;
            half();
            rd = {rd[6:0], serial_out};
            sclk_pin <= 1'b0;
        end
        half();
        cs_n_pin <= 1'b1;
        serial_in <= ~serial_in;
        half();
        half();
    endtask : frame
endmodule : bls_host

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // Power-up write delay of 5 ms at a 100 ns clock, plus the tests.
    localparam int LIMIT  = 70000;
    localparam int PU_DLY = 50000;
    logic       clk, rst, cs_n_pin, sclk_pin, serial_in, serial_out;
    logic       serial_out_oe, write_protect_select, protect_complement;
    logic       top_bottom_select, addr_4byte, prot_locked, array_op_busy;
    logic       status_busy, soft_reset_pulse;
    logic [3:0] protect_range_bits;
    logic [9:0] prot_index;
    int         errors = 0, n_tests = 0, cyc = 0, pulses = 0;

    bls_cmd u_dut (.clk, .rst, .cs_n_pin, .sclk_pin, .serial_in,
        .serial_out, .serial_out_oe, .write_protect_select,
        .protect_complement, .top_bottom_select, .protect_range_bits,
        .addr_4byte, .prot_index, .prot_locked, .array_op_busy,
        .status_busy, .soft_reset_pulse);
    bls_host u_host (.clk, .cs_n_pin, .sclk_pin, .serial_in, .serial_out);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (soft_reset_pulse === 1'b1)
            pulses <= pulses + 1;
        if (cyc == LIMIT) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk8(logic [7:0] got, logic [7:0] exp, string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8
    task automatic chk1(logic got, logic exp, string m);
        chk8({7'h00, got}, {7'h00, exp}, m);
    endtask : chk1
    task automatic done(string s);
        $display("test %s done", s);
    endtask : done
    task automatic cmd(logic [7:0] op, int nop);
        logic [7:0] rd;
        u_host.frame(op, nop, 32'h0, 0, 0, rd);
    endtask : cmd
    task automatic read_lock(logic exp);
        logic [31:0] a;
        logic [7:0]  rd;
        a = $urandom;
        a[31:26] = 6'h00;
        addr_4byte <= a[0];
        @(posedge clk);
        u_host.frame(bls_pkg::OPC_READ_LOCK, 8, a, a[0] ? 32 : 24, 2, rd);
        chk8(rd, {7'h00, exp}, "lock byte");
    endtask : read_lock
    task automatic prot(logic w, logic c, logic [3:0] r, logic exp);
        write_protect_select <= w;
        protect_complement   <= c;
        protect_range_bits   <= r;
        top_bottom_select    <= 1'($urandom);
        prot_index           <= 10'($urandom);
        repeat (3) @(posedge clk);
        chk1(prot_locked, exp, "protect");
    endtask : prot

    initial begin
        rst = 1'b1;
        {write_protect_select, protect_complement, top_bottom_select} = 3'h0;
        protect_range_bits = 4'h0;
        addr_4byte = 1'b0;
        prot_index = 10'h000;
        array_op_busy = 1'b0;
        void'($urandom(47810));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (PU_DLY) @(posedge clk);
        repeat (3) read_lock(1'b1);
        prot(1'b1, 1'b0, 4'h0, 1'b1);
        done("defaults");
        cmd(bls_pkg::OPC_GLOBAL_UNLOCK, 8);
        repeat (3) read_lock(1'b0);
        prot(1'b1, 1'b0, 4'hf, 1'b0);
        cmd(bls_pkg::OPC_GLOBAL_LOCK, 7);
        read_lock(1'b0);
        done("unlock");
        cmd(bls_pkg::OPC_GLOBAL_LOCK, 8);
        read_lock(1'b1);
        prot(1'b0, 1'b0, 4'h0, 1'b0);
        prot(1'b0, 1'b1, 4'h0, 1'b1);
        prot(1'b0, 1'b0, 4'hf, 1'b1);
        done("lock");
        cmd(bls_pkg::OPC_GLOBAL_UNLOCK, 8);
        chk1(status_busy, 1'b0, "busy");
        cmd(bls_pkg::OPC_RESET_ENABLE, 8);
        read_lock(1'b0);
        cmd(bls_pkg::OPC_RESET, 8);
        cmd(bls_pkg::OPC_RESET_ENABLE, 8);
        // An opcode the block does not decode still disarms the reset.
        cmd(8'h5a, 8);
        cmd(bls_pkg::OPC_RESET, 8);
        chk8(8'(pulses), 8'h00, "pulses");
        cmd(bls_pkg::OPC_RESET_ENABLE, 8);
        cmd(bls_pkg::OPC_RESET, 8);
        chk8(8'(pulses), 8'h01, "pulses");
        chk1(status_busy, 1'b1, "busy");
        cmd(bls_pkg::OPC_GLOBAL_UNLOCK, 8);
        for (int i = 0; i < 400 && status_busy !== 1'b0; i++)
            @(posedge clk);
        chk1(status_busy, 1'b0, "busy");
        read_lock(1'b1);
        done("reset");
        array_op_busy <= 1'b1;
        repeat (2) @(posedge clk);
        chk1(status_busy, 1'b1, "busy");
        array_op_busy <= 1'b0;
        repeat (2) @(posedge clk);
        chk1(status_busy, 1'b0, "busy");
        done("busy");
        finish_test();
    end
endmodule : tb_top
